// ===== src/fsr_pkg.sv
// shared constants for the floppy sector read controller
package fsr_pkg;

  // host port
  localparam int          FSR_AW       = 1;
  localparam int          FSR_DW       = 16;
  localparam logic [0:0]  FSR_CSR_IDX  = 1'h0;
  localparam logic [0:0]  FSR_DB_IDX   = 1'h1;

  // control/status field positions
  localparam int          FSR_GO_BIT   = 0;
  localparam int          FSR_FN_LSB   = 1;
  localparam int          FSR_UNIT_BIT = 4;
  localparam int          FSR_DONE_BIT = 5;
  localparam int          FSR_IE_BIT   = 6;
  localparam int          FSR_TR_BIT   = 7;
  localparam int          FSR_FM_BIT   = 8;
  localparam int          FSR_ERR_BIT  = 15;

  // commands
  localparam logic [2:0]  FSR_FN_READ  = 3'h3;
  localparam logic [2:0]  FSR_FN_XSTAT = 3'h7;

  // media layout
  localparam logic [7:0]  FSR_TRACKS   = 8'h4D;
  localparam logic [7:0]  FSR_SECTORS  = 8'h1A;
  localparam int          FSR_HDR_BITS = 56;
  localparam int          FSR_CRC_BITS = 16;
  localparam int          FSR_DC_BITS  = 8;
  localparam int          FSR_SEC_BITS = 2048;
  localparam int          FSR_BUF_AW   = 8;
  localparam int          FSR_HDR_TOT  = FSR_HDR_BITS + FSR_CRC_BITS;
  localparam int          FSR_DAT_TOT  = FSR_DC_BITS + FSR_SEC_BITS + FSR_CRC_BITS;
  localparam int          FSR_HDR_TRK  = 64;
  localparam int          FSR_HDR_SEC  = 56;

  // density codes in the data field
  localparam logic [7:0]  FSR_DC_MFM   = 8'hA5;
  localparam logic [7:0]  FSR_DC_FM    = 8'h5A;

  // crc
  localparam logic [15:0] FSR_CRC_INIT = 16'hFFFF;
  localparam logic [15:0] FSR_CRC_POLY = 16'h1021;

  // error codes in extended status word 1
  localparam logic [7:0]  FSR_EC_NONE  = 8'h00;
  localparam logic [7:0]  FSR_EC_HCRC  = 8'h01;
  localparam logic [7:0]  FSR_EC_ADDR  = 8'h02;
  localparam logic [7:0]  FSR_EC_TRK   = 8'h03;
  localparam logic [7:0]  FSR_EC_NFND  = 8'h04;
  localparam logic [7:0]  FSR_EC_DENS  = 8'h05;
  localparam logic [7:0]  FSR_EC_DCRC  = 8'h06;

  // error and status register bits
  localparam int          FSR_ES_DCRC  = 0;
  localparam int          FSR_ES_HCRC  = 1;
  localparam int          FSR_ES_DENS  = 2;

  // timing
  localparam int          FSR_CLK_NS   = 4;
  localparam int          FSR_T_STEP_MS = 6;
  localparam int          FSR_STEP_CYC = (FSR_T_STEP_MS * 1000000 + FSR_CLK_NS - 1) / FSR_CLK_NS;
  localparam int          FSR_HUNT_MAX = 2 * 26;

  typedef enum logic [3:0] {
    S_IDLE, S_REQ_SEC, S_REQ_TRK, S_SEEK, S_STEP_WAIT, S_HUNT,
    S_HDR, S_DWAIT, S_DATA, S_REQ_BA, S_XSTAT
  } fsr_state_t;

endpackage

// ===== src/fsr_buf.sv
// sector buffer memory, one write port and one registered read port
`timescale 1ns/1ns
module fsr_buf #(
  parameter int AW = 8,
  parameter int DW = 8
) (
  input  wire logic          i_clk,
  input  wire logic          i_we,
  input  wire logic [AW-1:0] i_waddr,
  input  wire logic [DW-1:0] i_wdata,
  input  wire logic [AW-1:0] i_raddr,
  output logic      [DW-1:0] o_rdata
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge i_clk) begin
    if (i_we) begin
      mem[i_waddr] <= i_wdata;
    end
    o_rdata <= mem[i_raddr];
  end

endmodule

// ===== src/fsr_ctrl.sv
// floppy sector read controller: host registers, seek, header hunt, sector read
`timescale 1ns/1ns
module fsr_ctrl
  import fsr_pkg::*;
#(
  parameter int unsigned STEP_CYC = FSR_STEP_CYC,
  parameter int unsigned HUNT_MAX = FSR_HUNT_MAX
) (
  input  wire logic                       I_CLK,
  input  wire logic                       I_RST_N,
  input  wire logic [fsr_pkg::FSR_AW-1:0] I_ADDR,
  input  wire logic [fsr_pkg::FSR_DW-1:0] I_WDATA,
  input  wire logic                       I_WR,
  input  wire logic                       I_RD,
  output logic      [fsr_pkg::FSR_DW-1:0] O_RDATA,
  input  wire logic                       I_BIT,
  input  wire logic                       I_BIT_VLD,
  input  wire logic                       I_HDR_MARK,
  input  wire logic                       I_DATA_MARK,
  output logic                            O_STEP,
  output logic                            O_STEP_IN,
  output logic                            O_UNIT,
  output logic                            O_MFM,
  output logic                            O_WR_GATE,
  output logic                            O_IRQ,
  output logic                            O_MEM_WE,
  output logic      [fsr_pkg::FSR_DW-1:0] O_MEM_ADDR,
  output logic      [fsr_pkg::FSR_DW-1:0] O_MEM_WDATA,
  input  wire logic [fsr_pkg::FSR_BUF_AW-1:0] I_BUF_RADDR,
  output logic      [7:0]                 O_BUF_RDATA
);
  import fsr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? FSR_CRC_POLY : 16'h0000);
  endfunction

  fsr_state_t        state_reg;
  logic [2:0]        fn_reg;
  logic              ie_reg;
  logic              fm_reg;
  logic              unit_reg;
  logic              tr_reg;
  logic              done_reg;
  logic              err_reg;
  logic [7:0]        sec_reg;
  logic [7:0]        trk_reg;
  logic [7:0]        cur_trk_reg;
  logic [20:0]       wait_cnt_reg;
  logic [11:0]       bit_cnt_reg;
  logic [7:0]        hunt_cnt_reg;
  logic [71:0]       sh_reg;
  logic [15:0]       crc_reg;
  logic [7:0]        ec_reg;
  logic [2:0]        es_reg;
  logic [7:0]        dc_reg;
  logic [7:0]        byte_reg;
  logic              buf_we_reg;
  logic [7:0]        buf_waddr_reg;
  logic [FSR_DW-1:0] ba_reg;
  logic [2:0]        xw_reg;
  logic              step_reg;
  logic              dir_reg;
  logic [FSR_DW-1:0] rdata_reg;
  logic              mem_we_reg;
  logic [FSR_DW-1:0] mem_addr_reg;
  logic [FSR_DW-1:0] mem_wdata_reg;

  logic              csr_wr;
  logic              db_wr;
  logic              go;
  logic [71:0]       sh_next;
  logic [15:0]       crc_next;
  logic [7:0]        exp_dc;

  assign csr_wr   = I_WR && (I_ADDR == FSR_CSR_IDX);
  assign db_wr    = I_WR && (I_ADDR == FSR_DB_IDX);
  assign go       = csr_wr && I_WDATA[FSR_GO_BIT] && (state_reg == S_IDLE);
  assign sh_next  = {sh_reg[70:0], I_BIT};
  assign crc_next = crc_step(crc_reg, I_BIT);
  assign exp_dc   = fm_reg ? FSR_DC_FM : FSR_DC_MFM;

  ////////////////////////////////////////////////////////////////////////////
  // software-owned control bits; function, unit and density only change
  // while idle so a running read never switches mid-sector
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      ie_reg   <= 1'b0;
      fm_reg   <= 1'b0;
      unit_reg <= 1'b0;
      fn_reg   <= 3'h0;
    end else if (csr_wr) begin
      ie_reg <= I_WDATA[FSR_IE_BIT];
      if (state_reg == S_IDLE) begin
        fm_reg   <= I_WDATA[FSR_FM_BIT];
        unit_reg <= I_WDATA[FSR_UNIT_BIT];
        fn_reg   <= I_WDATA[FSR_FN_LSB +: 3];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // host read port, data one cycle after the strobe
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      rdata_reg <= 16'h0000;
    end else if (I_RD) begin
      if (I_ADDR == FSR_CSR_IDX) begin
        rdata_reg                <= 16'h0000;
        rdata_reg[FSR_FN_LSB+:3] <= fn_reg;
        rdata_reg[FSR_UNIT_BIT]  <= unit_reg;
        rdata_reg[FSR_DONE_BIT]  <= done_reg;
        rdata_reg[FSR_IE_BIT]    <= ie_reg;
        rdata_reg[FSR_TR_BIT]    <= tr_reg;
        rdata_reg[FSR_FM_BIT]    <= fm_reg;
        rdata_reg[FSR_ERR_BIT]   <= err_reg;
      end else begin
        rdata_reg <= {13'h0000, es_reg};
      end
    end else begin
      rdata_reg <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // command sequencer
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      state_reg     <= S_IDLE;
      tr_reg        <= 1'b0;
      done_reg      <= 1'b1;
      err_reg       <= 1'b0;
      sec_reg       <= 8'h00;
      trk_reg       <= 8'h00;
      cur_trk_reg   <= 8'h00;
      wait_cnt_reg  <= 21'h000000;
      bit_cnt_reg   <= 12'h000;
      hunt_cnt_reg  <= 8'h00;
      sh_reg        <= 72'h0;
      crc_reg       <= FSR_CRC_INIT;
      ec_reg        <= FSR_EC_NONE;
      es_reg        <= 3'h0;
      dc_reg        <= 8'h00;
      byte_reg      <= 8'h00;
      buf_we_reg    <= 1'b0;
      buf_waddr_reg <= 8'h00;
      ba_reg        <= 16'h0000;
      xw_reg        <= 3'h0;
      step_reg      <= 1'b0;
      dir_reg       <= 1'b0;
      mem_we_reg    <= 1'b0;
      mem_addr_reg  <= 16'h0000;
      mem_wdata_reg <= 16'h0000;
    end else begin
      step_reg   <= 1'b0;
      buf_we_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      unique case (state_reg)
        S_IDLE: begin
          if (go) begin
            done_reg <= 1'b0;
            err_reg  <= 1'b0;
            if (I_WDATA[FSR_FN_LSB +: 3] == FSR_FN_READ) begin
              tr_reg    <= 1'b1;
              ec_reg    <= FSR_EC_NONE;
              es_reg    <= 3'h0;
              state_reg <= S_REQ_SEC;
            end else if (I_WDATA[FSR_FN_LSB +: 3] == FSR_FN_XSTAT) begin
              tr_reg    <= 1'b1;
              state_reg <= S_REQ_BA;
            end else begin
              done_reg <= 1'b1;
            end
          end
        end
        S_REQ_SEC: begin
          if (db_wr) begin
            sec_reg   <= I_WDATA[7:0];
            tr_reg    <= 1'b0;
            state_reg <= S_REQ_TRK;
          end
        end
        S_REQ_TRK: begin
          if (!tr_reg) begin
            tr_reg <= 1'b1;
          end else if (db_wr) begin
            trk_reg <= I_WDATA[7:0];
            tr_reg  <= 1'b0;
            if (I_WDATA[15:0] >= {8'h00, FSR_TRACKS} || sec_reg == 8'h00 ||
                sec_reg > FSR_SECTORS) begin
              ec_reg    <= FSR_EC_ADDR;
              err_reg   <= 1'b1;
              state_reg <= S_IDLE;
            end else begin
              state_reg <= S_SEEK;
            end
          end
        end
        S_SEEK: begin
          if (cur_trk_reg == trk_reg) begin
            hunt_cnt_reg <= 8'h00;
            state_reg    <= S_HUNT;
          end else begin
            step_reg     <= 1'b1;
            dir_reg      <= (trk_reg > cur_trk_reg);
            cur_trk_reg  <= (trk_reg > cur_trk_reg) ? cur_trk_reg + 8'h01
                                                    : cur_trk_reg - 8'h01;
            wait_cnt_reg <= 21'h000000;
            state_reg    <= S_STEP_WAIT;
          end
        end
        S_STEP_WAIT: begin
          // the head must settle one step time before the next move
          wait_cnt_reg <= wait_cnt_reg + 21'h000001;
          if (wait_cnt_reg == 21'(STEP_CYC - 1)) begin
            state_reg <= S_SEEK;
          end
        end
        S_HUNT: begin
          if (I_HDR_MARK) begin
            bit_cnt_reg <= 12'h000;
            crc_reg     <= FSR_CRC_INIT;
            state_reg   <= S_HDR;
          end
        end
        S_HDR: begin
          if (I_BIT_VLD) begin
            sh_reg      <= sh_next;
            bit_cnt_reg <= bit_cnt_reg + 12'h001;
            if (bit_cnt_reg < 12'(FSR_HDR_BITS)) begin
              crc_reg <= crc_next;
            end
            if (bit_cnt_reg == 12'(FSR_HDR_TOT - 1)) begin
              if (sh_next[15:0] != crc_reg) begin
                ec_reg    <= FSR_EC_HCRC;
                es_reg[FSR_ES_HCRC] <= 1'b1;
                err_reg   <= 1'b1;
                state_reg <= S_IDLE;
              end else if (sh_next[FSR_HDR_TRK +: 8] != trk_reg) begin
                ec_reg    <= FSR_EC_TRK;
                err_reg   <= 1'b1;
                state_reg <= S_IDLE;
              end else if (sh_next[FSR_HDR_SEC +: 8] == sec_reg) begin
                state_reg <= S_DWAIT;
              end else if (hunt_cnt_reg == 8'(HUNT_MAX - 1)) begin
                // two turns without a match: give up rather than spin
                ec_reg    <= FSR_EC_NFND;
                err_reg   <= 1'b1;
                state_reg <= S_IDLE;
              end else begin
                hunt_cnt_reg <= hunt_cnt_reg + 8'h01;
                state_reg    <= S_HUNT;
              end
            end
          end
        end
        S_DWAIT: begin
          if (I_DATA_MARK) begin
            bit_cnt_reg   <= 12'h000;
            buf_waddr_reg <= 8'hFF;
            crc_reg       <= FSR_CRC_INIT;
            state_reg     <= S_DATA;
          end
        end
        S_DATA: begin
          if (I_BIT_VLD) begin
            sh_reg      <= sh_next;
            bit_cnt_reg <= bit_cnt_reg + 12'h001;
            if (bit_cnt_reg < 12'(FSR_DC_BITS + FSR_SEC_BITS)) begin
              crc_reg <= crc_next;
            end
            if (bit_cnt_reg < 12'(FSR_DC_BITS)) begin
              dc_reg <= sh_next[7:0];
            end else if (bit_cnt_reg < 12'(FSR_DC_BITS + FSR_SEC_BITS)) begin
              byte_reg <= sh_next[7:0];
              if (bit_cnt_reg[2:0] == 3'h7) begin
                buf_we_reg    <= 1'b1;
                buf_waddr_reg <= buf_waddr_reg + 8'h01;
              end
            end
            if (bit_cnt_reg == 12'(FSR_DAT_TOT - 1)) begin
              state_reg <= S_IDLE;
              if (sh_next[15:0] != crc_reg) begin
                es_reg[FSR_ES_DCRC] <= 1'b1;
                ec_reg  <= FSR_EC_DCRC;
                err_reg <= 1'b1;
              end else if (dc_reg != exp_dc) begin
                es_reg[FSR_ES_DENS] <= 1'b1;
                ec_reg  <= FSR_EC_DENS;
                err_reg <= 1'b1;
              end else begin
                done_reg <= 1'b1;
              end
            end
          end
        end
        S_REQ_BA: begin
          if (db_wr) begin
            ba_reg    <= I_WDATA;
            tr_reg    <= 1'b0;
            xw_reg    <= 3'h0;
            state_reg <= S_XSTAT;
          end
        end
        S_XSTAT: begin
          if (xw_reg == 3'h4) begin
            done_reg  <= 1'b1;
            state_reg <= S_IDLE;
          end else begin
            mem_we_reg   <= 1'b1;
            mem_addr_reg <= ba_reg + {12'h000, xw_reg[1:0], 1'b0, 1'b0} -
                            {13'h0000, xw_reg[1:0], 1'b0};
            unique case (xw_reg[1:0])
              2'h0:    mem_wdata_reg <= {8'h00, ec_reg};
              2'h1:    mem_wdata_reg <= {trk_reg, sec_reg};
              2'h2:    mem_wdata_reg <= {cur_trk_reg, dc_reg};
              default: mem_wdata_reg <= {fm_reg, unit_reg, 11'h000, es_reg};
            endcase
            xw_reg <= xw_reg + 3'h1;
          end
        end
        default: state_reg <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  fsr_buf #(
    .AW (FSR_BUF_AW),
    .DW (8)
  ) u_buf (
    .i_clk   (I_CLK),
    .i_we    (buf_we_reg),
    .i_waddr (buf_waddr_reg),
    .i_wdata (byte_reg),
    .i_raddr (I_BUF_RADDR),
    .o_rdata (O_BUF_RDATA)
  );

  assign O_RDATA     = rdata_reg;
  assign O_STEP      = step_reg;
  assign O_STEP_IN   = dir_reg;
  assign O_UNIT      = unit_reg;
  assign O_MFM       = !fm_reg;
  assign O_WR_GATE   = 1'b0;
  assign O_IRQ       = ie_reg && (err_reg || done_reg);
  assign O_MEM_WE    = mem_we_reg;
  assign O_MEM_ADDR  = mem_addr_reg;
  assign O_MEM_WDATA = mem_wdata_reg;

endmodule

// ===== verification/fsr_ctrl_assertions.sv
// port checker for the floppy sector read controller
`timescale 1ns/1ns
module fsr_ctrl_chk (
  input wire logic                       I_CLK,
  input wire logic                       I_RST_N,
  input wire logic [fsr_pkg::FSR_AW-1:0] I_ADDR,
  input wire logic [fsr_pkg::FSR_DW-1:0] I_WDATA,
  input wire logic                       I_WR,
  input wire logic                       I_RD,
  input wire logic [fsr_pkg::FSR_DW-1:0] O_RDATA,
  input wire logic                       O_STEP,
  input wire logic                       O_MFM,
  input wire logic                       O_WR_GATE,
  input wire logic                       O_IRQ,
  input wire logic                       O_MEM_WE,
  input wire logic [fsr_pkg::FSR_DW-1:0] O_MEM_ADDR
);
  import fsr_pkg::*;
  default clocking @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);
  logic [1:0]  wcnt_reg;
  logic [15:0] last_reg;
  // status words come in groups of four; track where we are in the group
  always_ff @(posedge I_CLK) begin
    if (!I_RST_N) begin
      wcnt_reg <= 2'h0;
      last_reg <= 16'h0000;
    end else if (O_MEM_WE) begin
      wcnt_reg <= wcnt_reg + 2'h1;
      last_reg <= O_MEM_ADDR;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  wr_gate_off_a: assert property (!O_WR_GATE)
    else $error("write gate raised");
  rdata_quiet_a: assert property (!$past(I_RD) |-> O_RDATA == 16'h0000)
    else $error("read data outside read cycle");
  req_clear_a: assert property ((I_WR && I_ADDR == FSR_DB_IDX) ##1
    (I_RD && I_ADDR == FSR_CSR_IDX) |=> !O_RDATA[FSR_TR_BIT]) else $error("request kept");
  go_req_a: assert property ((I_WR && I_ADDR == FSR_CSR_IDX && I_WDATA[3:0] == 4'h7) ##1
    (I_RD && I_ADDR == FSR_CSR_IDX) |=> O_RDATA[FSR_TR_BIT]) else $error("no request");
  irq_flag_a: assert property ($past(I_RD && I_ADDR == FSR_CSR_IDX) |->
    (O_RDATA[6] && (O_RDATA[15] || O_RDATA[5])) == $past(O_IRQ)) else $error("irq mismatch");
  step_gap_a: assert property (O_STEP |=> !O_STEP [*3])
    else $error("step pulses too close");
  dens_sel_a: assert property ($changed(O_MFM) |-> $past(I_WR && I_ADDR == FSR_CSR_IDX)
    && (O_MFM != $past(I_WDATA[FSR_FM_BIT]))) else $error("density changed");
  mem_step_a: assert property (O_MEM_WE && wcnt_reg != 2'h0 |->
    O_MEM_ADDR == last_reg + 16'h0002) else $error("status word address");
  cover property (O_STEP);
  cover property (O_MEM_WE);
  cover property (O_IRQ);
endmodule
bind fsr_ctrl fsr_ctrl_chk chk (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR),
  .I_WDATA(I_WDATA), .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .O_STEP(O_STEP),
  .O_MFM(O_MFM), .O_WR_GATE(O_WR_GATE), .O_IRQ(O_IRQ), .O_MEM_WE(O_MEM_WE),
  .O_MEM_ADDR(O_MEM_ADDR));

// ===== verification/fsr_drive_model.sv
// behavioural drive that streams header and data fields as bit cells
`timescale 1ns/1ns
module fsr_drive_model (
  input  wire logic i_clk,
  output logic      o_bit,
  output logic      o_bit_vld,
  output logic      o_hdr_mark,
  output logic      o_data_mark
);
  import fsr_pkg::*;
  initial begin
    o_bit       = 1'b0;
    o_bit_vld   = 1'b0;
    o_hdr_mark  = 1'b0;
    o_data_mark = 1'b0;
  end
  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? FSR_CRC_POLY : 16'h0000);
  endfunction
  function automatic logic [7:0] pat(input int k);
    pat = 8'(k) ^ 8'h5C;
  endfunction
  // outside a cell the line shows the inverse, so a stale bit is never reused
  task automatic put(input logic b, input int gap);
    @(posedge i_clk);
    o_bit     <= b;
    o_bit_vld <= 1'b1;
    @(posedge i_clk);
    o_bit_vld <= 1'b0;
    o_bit     <= ~b;
    repeat (gap) @(posedge i_clk);
  endtask
  task automatic mark(input logic hdr);
    @(posedge i_clk);
    o_hdr_mark  <= hdr;
    o_data_mark <= !hdr;
    @(posedge i_clk);
    o_hdr_mark  <= 1'b0;
    o_data_mark <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic send(input logic [7:0] trk, input logic [7:0] sec, input logic [7:0] dc,
                      input logic [15:0] hflip, input logic [15:0] dflip, input int gap);
    logic [71:0] h;
    logic [15:0] c;
    logic [7:0]  b;
    h = {trk, sec, 56'h0};
    c = FSR_CRC_INIT;
    for (int i = 71; i >= 16; i--)
      c = crc_step(c, h[i]);
    h[15:0] = c ^ hflip;
    mark(1'b1);
    for (int i = 71; i >= 0; i--)
      put(h[i], gap);
    c = FSR_CRC_INIT;
    mark(1'b0);
    for (int k = 0; k < 257; k++) begin
      b = (k == 0) ? dc : pat(k - 1);
      for (int j = 7; j >= 0; j--) begin
        c = crc_step(c, b[j]);
        put(b[j], gap);
      end
    end
    c = c ^ dflip;
    for (int j = 15; j >= 0; j--)
      put(c[j], gap);
  endtask
endmodule

// ===== verification/tb_floppy_sector_read_controller.sv
// self-checking bench for the floppy sector read controller
`timescale 1ns/1ns
module tb_floppy_sector_read_controller;
  import fsr_pkg::*;
  localparam int STEP = 4;
  logic        clk, rst_n, wr_s, rd_s, bit_w, vld_w, hm_w, dm_w, o_step, o_step_in;
  logic        o_unit, o_mfm, o_wr_gate, o_irq, mem_we;
  logic [0:0]  addr;
  logic [15:0] wdata, o_rdata, mem_addr, mem_wdata, v;
  logic [7:0]  raddr, o_buf_rdata;
  logic [15:0] mem_a[$];
  logic [15:0] mem_d[$];
  int          fail_count = 0;
  int          samples_checked = 0;
  int          steps = 0;
  int          cur = 0;
  logic        dir_e = 1'b0;
  fsr_ctrl #(.STEP_CYC(STEP)) uut (.I_CLK(clk), .I_RST_N(rst_n), .I_ADDR(addr),
    .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(o_rdata), .I_BIT(bit_w),
    .I_BIT_VLD(vld_w), .I_HDR_MARK(hm_w), .I_DATA_MARK(dm_w), .O_STEP(o_step),
    .O_STEP_IN(o_step_in), .O_UNIT(o_unit), .O_MFM(o_mfm), .O_WR_GATE(o_wr_gate),
    .O_IRQ(o_irq), .O_MEM_WE(mem_we), .O_MEM_ADDR(mem_addr), .O_MEM_WDATA(mem_wdata),
    .I_BUF_RADDR(raddr), .O_BUF_RDATA(o_buf_rdata));
  fsr_drive_model drv (.i_clk(clk), .o_bit(bit_w), .o_bit_vld(vld_w), .o_hdr_mark(hm_w),
    .o_data_mark(dm_w));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (o_step)
      steps++;
    if (mem_we) begin
      mem_a.push_back(mem_addr);
      mem_d.push_back(mem_wdata);
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // a bus cycle holds until the next call, so calls run back to back
  task automatic bus(input logic w, input logic r, input logic a, input logic [15:0] d);
    @(posedge clk);
    wr_s  <= w;
    rd_s  <= r;
    addr  <= a;
    wdata <= d;
  endtask
  task automatic rd(input logic a, output logic [15:0] q);
    bus(1'b0, 1'b1, a, 16'h0000);
    bus(1'b0, 1'b0, a, 16'h0000);
    @(negedge clk);
    q = o_rdata;
  endtask
  task automatic poll(input logic [15:0] mask, output logic [15:0] q);
    for (int i = 0; i < 300; i++) begin
      rd(1'b0, q);
      if ((q & mask) != 16'h0000)
        break;
    end
  endtask
  task automatic read_sec(input logic [7:0] trk, input logic [7:0] sec, input logic fm,
                          input logic [15:0] hf, input logic [15:0] df);
    int n;
    n = (trk > cur) ? trk - cur : cur - trk;
    bus(1'b1, 1'b0, 1'b0, {7'h0, fm, 8'h47});
    rd(1'b0, v);
    chk(v[7], 1'b1);
    chk(o_mfm, !fm);
    bus(1'b1, 1'b0, 1'b1, {8'h00, sec});
    rd(1'b0, v);
    chk(v[7], 1'b0);
    poll(16'h0080, v);
    steps = 0;
    bus(1'b1, 1'b0, 1'b1, {8'h00, trk});
    rd(1'b0, v);
    chk(v[7], 1'b0);
    if (trk < FSR_TRACKS) begin
      for (int i = 0; i < 2000 && steps < n; i++)
        @(posedge clk);
      chk(16'(steps), 16'(n));
      // direction only moves with a step, so a zero-length seek keeps the old one
      if (n > 0)
        dir_e = (trk > cur);
      chk(o_step_in, dir_e);
      repeat (STEP + 4) @(posedge clk);
      cur = trk;
      drv.send(trk, sec + 8'h01, fm ? FSR_DC_FM : FSR_DC_MFM, 16'h0, 16'h0, 0);
      drv.send(trk, sec, fm ? FSR_DC_FM : FSR_DC_MFM, hf, df, fm ? 1 : 0);
    end
    poll(16'h8020, v);
  endtask
  task automatic t_good(input logic [7:0] trk, input logic [7:0] sec, input logic fm);
    read_sec(trk, sec, fm, 16'h0, 16'h0);
    chk(v & 16'h8020, 16'h0020);
    chk(o_irq, 1'b1);
    for (int k = 0; k < 256; k += 85) begin
      bus(1'b0, 1'b0, 1'b0, 16'h0000);
      raddr <= 8'(k);
      @(posedge clk);
      @(negedge clk);
      chk(o_buf_rdata, drv.pat(k));
    end
  endtask
  task automatic t_irq_mask;
    bus(1'b1, 1'b0, 1'b0, 16'h0000);
    bus(1'b0, 1'b0, 1'b0, 16'h0000);
    @(negedge clk);
    chk(o_irq, 1'b0);
    bus(1'b1, 1'b0, 1'b0, 16'h0050);
    rd(1'b0, v);
    chk(o_irq, 1'b1);
    chk(o_unit, 1'b1);
    chk(v[FSR_UNIT_BIT], 1'b1);
  endtask
  task automatic t_errors;
    read_sec(8'd76, 8'd3, 1'b0, 16'h0, 16'h0001);
    chk(v[15], 1'b1);
    rd(1'b1, v);
    chk(v[FSR_ES_DCRC], 1'b1);
    read_sec(8'd77, 8'd1, 1'b0, 16'h0, 16'h0);
    chk(v[15], 1'b1);
    read_sec(8'd40, 8'd7, 1'b0, 16'h8000, 16'h0);
    chk(v[15], 1'b1);
    mem_a.delete();
    mem_d.delete();
    bus(1'b1, 1'b0, 1'b0, 16'h004F);
    rd(1'b0, v);
    chk(v[7], 1'b1);
    bus(1'b1, 1'b0, 1'b1, 16'h0100);
    poll(16'h0020, v);
    chk(16'(mem_a.size()), 16'h0004);
    for (int i = 0; i < 4 && i < mem_a.size(); i++)
      chk(mem_a[i], 16'h0100 + 16'(2 * i));
    if (mem_d.size() > 1) begin
      chk(mem_d[0], {8'h00, FSR_EC_HCRC});
      chk(mem_d[1], {8'd40, 8'd7});
    end
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    wr_s  = 1'b0;
    rd_s  = 1'b0;
    addr  = 1'b0;
    wdata = 16'h0000;
    raddr = 8'h00;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    rd(1'b0, v);
    chk(v, 16'h0020);
    chk(o_mfm, 1'b1);
    chk(o_wr_gate, 1'b0);
    t_good(8'd5, 8'd1, 1'b0);
    t_good(8'd76, 8'd26, 1'b1);
    t_irq_mask();
    t_errors();
    test_done();
  end
  initial begin
    #360000;
    fail_count++;
    test_done();
  end
endmodule
